// File: design/priority_interrupt_control.v
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "prio_int_consts.vh"

module priority_interrupt_control
(
    input  wire        clk,
    input  wire        arst_n,
    input  wire [7:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    input  wire [7:0]  src_event,
    input  wire [3:0]  trap_event,
    input  wire        take_ack,
    input  wire [15:0] take_pc,
    input  wire        ret_strobe,
    output reg         irq_req,
    output reg  [3:0]  irq_vec,
    output reg  [3:0]  irq_lvl,
    output reg  [3:0]  cpu_level,
    output reg         ret_valid,
    output reg  [15:0] ret_pc,
    output reg         int_out
);

// ----------------------------------------
// state
// ----------------------------------------
reg                    nest_dis_reg;
reg                    stk_err_reg;
reg [3:0]              trap_flag_reg;
reg [15:0]             icon2_reg;
reg [7:0]              pend_reg;
reg [7:0]              enable_reg;
reg [15:0]             prio_a_reg;
reg [15:0]             prio_b_reg;
reg [3:0]              lvl_reg;
reg [3:0]              sr_misc_reg;
reg [`TDIS_W-1:0]      tdis_cnt_reg;
reg [`STK_PTR_W-1:0]   stk_ptr_reg;
reg [`STK_W-1:0]       stk_mem [0:`STK_DEPTH-1];

// ----------------------------------------
// helpers
// ----------------------------------------
// priority field of user source idx; sources 6 and 7 are serial errors
function [2:0] src_prio;
    input [15:0] pa;
    input [15:0] pb;
    input [15:0] ic2;
    input [2:0]  idx;
    begin
        case (idx)
            3'h0:    src_prio = pa[2:0];
            3'h1:    src_prio = pa[6:4];
            3'h2:    src_prio = pa[10:8];
            3'h3:    src_prio = pa[14:12];
            3'h4:    src_prio = pb[2:0];
            3'h5:    src_prio = pb[6:4];
            3'h6:    src_prio = ic2[6:4];
            3'h7:    src_prio = ic2[10:8];
            default: src_prio = 3'h0;
        endcase
    end
endfunction

function [7:0] status_byte;
    input [3:0] misc;
    input [3:0] lvl;
    begin
        status_byte = {misc[3:1], lvl, misc[0]};
    end
endfunction

// widen a three-bit priority onto the four-bit level scale
function [3:0] user_lvl;
    input [2:0] pr;
    begin
        user_lvl = {1'b0, pr};
    end
endfunction

// ----------------------------------------
// arbitration
// ----------------------------------------
wire       tdis_active = (tdis_cnt_reg != {`TDIS_W{1'b0}});
wire       in_handler  = (stk_ptr_reg != {`STK_PTR_W{1'b0}});
// a take on a full stack still raises the level; only the push is lost
wire       stk_full    = (stk_ptr_reg == `STK_FULL_PTR);
wire [7:0] cur_status  = status_byte(sr_misc_reg, lvl_reg);

reg        found;
reg [3:0]  best_lvl;
reg [3:0]  best_vec;
reg [2:0]  p;
reg [3:0]  tl;
integer    i;

always @*
begin
    found    = 1'b0;
    best_lvl = 4'h0;
    best_vec = 4'h0;
    p        = 3'h0;
    tl       = 4'h0;
    for (i = 0; i < `NUM_USER; i = i + 1)
    begin
        p = src_prio(prio_a_reg, prio_b_reg, icon2_reg, i[2:0]);
        if (pend_reg[i] && enable_reg[i]
            && p != 3'h0
            && user_lvl(p) > lvl_reg
            && !(tdis_active && user_lvl(p) != `LVL_USER_MAX)
            && !(nest_dis_reg && in_handler)
            && user_lvl(p) > best_lvl)
        begin
            found    = 1'b1;
            best_lvl = user_lvl(p);
            best_vec = `USER_VEC_BASE + {1'b0, i[2:0]};
        end
    end
    // traps sit above every user level and are never masked by tdis
    for (i = 0; i < `NUM_TRAPS; i = i + 1)
    begin
        tl = `TRAP_BASE + {2'h0, i[1:0]};
        if (trap_flag_reg[i] && tl > lvl_reg && tl > best_lvl)
        begin
            found    = 1'b1;
            best_lvl = tl;
            best_vec = {2'h0, i[1:0]};
        end
    end
end

// ----------------------------------------
// register writes and status
// ----------------------------------------
wire wr_icon1  = wr && (addr == `ADDR_ICON1);
wire wr_icon2  = wr && (addr == `ADDR_ICON2);
wire wr_pend   = wr && (addr == `ADDR_PEND);
wire wr_enable = wr && (addr == `ADDR_ENABLE);
wire wr_prio_a = wr && (addr == `ADDR_PRIO_A);
wire wr_prio_b = wr && (addr == `ADDR_PRIO_B);
wire wr_status = wr && (addr == `ADDR_STATUS);
wire wr_tdis   = wr && (addr == `ADDR_TDIS);

// a take is only honoured while a request is shown
wire do_take = take_ack && irq_req;
// a return in the same cycle as a take is dropped; the core never does both
wire do_ret  = ret_strobe && !do_take && in_handler;

// the pointer counts entries, so the newest context sits one slot below it
wire [2:0]        stk_top_idx = stk_ptr_reg[2:0] - 3'h1;
wire [`STK_W-1:0] stk_top     = stk_mem[stk_top_idx];

always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        nest_dis_reg  <= 1'b0;
        stk_err_reg   <= 1'b0;
        trap_flag_reg <= 4'h0;
        icon2_reg     <= `ICON2_RESET;
        pend_reg      <= 8'h00;
        enable_reg    <= 8'h00;
        prio_a_reg    <= `PRIO_A_RESET;
        prio_b_reg    <= `PRIO_B_RESET;
        tdis_cnt_reg  <= {`TDIS_W{1'b0}};
    end
    else
    begin
        if (wr_icon1)
        begin
            nest_dis_reg <= wdata[`NEST_BIT];
        end
        // set wins over the write-one clear
        trap_flag_reg <= (trap_flag_reg & ~(wr_icon1 ? wdata[3:0] : 4'h0))
                         | trap_event;
        stk_err_reg   <= (stk_err_reg & ~(wr_icon1 && wdata[`STKERR_BIT]))
                         | (do_take && stk_full);
        // only software clears a pending flag, never a take or a return
        pend_reg      <= (pend_reg & ~(wr_pend ? wdata[7:0] : 8'h00))
                         | src_event;
        if (wr_enable)
        begin
            enable_reg <= wdata[7:0];
        end
        if (wr_icon2)
        begin
            icon2_reg <= wdata & `ICON2_MASK;
        end
        if (wr_prio_a)
        begin
            prio_a_reg <= wdata & `PRIO_A_MASK;
        end
        if (wr_prio_b)
        begin
            prio_b_reg <= wdata & `PRIO_B_MASK;
        end
        if (wr_tdis)
        begin
            tdis_cnt_reg <= wdata[`TDIS_W-1:0];
        end
        else if (tdis_active)
        begin
            tdis_cnt_reg <= tdis_cnt_reg - {{(`TDIS_W-1){1'b0}}, 1'b1};
        end
    end
end

// ----------------------------------------
// cpu level, context stack
// ----------------------------------------
// the stack is kept here so that a return restores exactly what a take saved
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        lvl_reg     <= 4'h0;
        sr_misc_reg <= 4'h0;
        stk_ptr_reg <= {`STK_PTR_W{1'b0}};
        ret_valid   <= 1'b0;
        ret_pc      <= 16'h0000;
    end
    else
    begin
        ret_valid <= 1'b0;
        if (do_take)
        begin
            if (!stk_full)
            begin
                stk_ptr_reg <= stk_ptr_reg + 4'h1;
            end
            lvl_reg <= irq_lvl;
        end
        else if (do_ret)
        begin
            // restored level lets a still pending source win again
            ret_pc      <= stk_top[15:0];
            sr_misc_reg <= {stk_top[23:21], stk_top[16]};
            lvl_reg     <= stk_top[20:17];
            stk_ptr_reg <= stk_ptr_reg - 4'h1;
            ret_valid   <= 1'b1;
        end
        else if (wr_status)
        begin
            // or-ing 0eh into the low byte puts the level at seven, except at a trap level (bit 3 set), which is kept
            sr_misc_reg <= {wdata[7:5], wdata[0]};
            if (!lvl_reg[3])
            begin
                lvl_reg <= user_lvl(wdata[3:1]);
            end
        end
    end
end

always @(posedge clk)
begin
    if (do_take && !stk_full)
    begin
        stk_mem[stk_ptr_reg[2:0]] <= {cur_status, take_pc};
    end
end

// ----------------------------------------
// request outputs
// ----------------------------------------
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        irq_req   <= 1'b0;
        irq_vec   <= 4'h0;
        irq_lvl   <= 4'h0;
        cpu_level <= 4'h0;
        int_out   <= 1'b0;
    end
    else
    begin
        // one idle cycle after a take lets the raised level settle
        irq_req   <= found && !do_take && !do_ret;
        irq_vec   <= best_vec;
        irq_lvl   <= best_lvl;
        cpu_level <= do_take ? irq_lvl : (do_ret ? stk_top[20:17] : lvl_reg);
        int_out   <= |(pend_reg & enable_reg);
    end
end

// ----------------------------------------
// read port
// ----------------------------------------
reg [15:0] rd_mux;

always @*
begin
    rd_mux = 16'h0000;
    case (addr)
        `ADDR_ICON1:
        begin
            rd_mux[`NEST_BIT]   = nest_dis_reg;
            rd_mux[`TDIS_BIT]   = tdis_active;
            rd_mux[`STKERR_BIT] = stk_err_reg;
            rd_mux[3:0]         = trap_flag_reg;
        end
        `ADDR_ICON2:  rd_mux = icon2_reg;
        `ADDR_PEND:   rd_mux = {8'h00, pend_reg};
        `ADDR_ENABLE: rd_mux = {8'h00, enable_reg};
        `ADDR_PRIO_A: rd_mux = prio_a_reg;
        `ADDR_PRIO_B: rd_mux = prio_b_reg;
        `ADDR_STATUS: rd_mux = {8'h00, cur_status};
        `ADDR_TDIS:   rd_mux = {2'h0, tdis_cnt_reg};
        default:      rd_mux = 16'h0000;
    endcase
end

always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        rdata <= 16'h0000;
    end
    else
    begin
        rdata <= rd ? rd_mux : 16'h0000;
    end
end

endmodule // priority_interrupt_control

// File: design/prio_int_consts.vh
`ifndef PRIO_INT_CONSTS_VH
`define PRIO_INT_CONSTS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ADDR_ICON1      8'h00
`define ADDR_ICON2      8'h02
`define ADDR_PEND       8'h04
`define ADDR_ENABLE     8'h06
`define ADDR_PRIO_A     8'h08
`define ADDR_PRIO_B     8'h0a
`define ADDR_STATUS     8'h0c
`define ADDR_TDIS       8'h0e

// ----------------------------------------
// field positions
// ----------------------------------------
`define NEST_BIT        15
`define TDIS_BIT        14
`define STKERR_BIT      4
`define NUM_TRAPS       4
`define NUM_USER        8
`define NUM_GEN         6
`define LVL_LSB         1
`define LVL_MSB         4

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define PRIO_RESET      3'h4
`define PRIO_A_RESET    16'h4444
`define PRIO_B_RESET    16'h0044
`define PRIO_A_MASK     16'h7777
`define PRIO_B_MASK     16'h0077
`define ICON2_RESET     16'h0440
`define ICON2_MASK      16'h0770
`define STATUS_RESET    8'h00
`define LVL_USER_MAX    4'h7
`define TRAP_BASE       4'h8
`define USER_VEC_BASE   4'h4

// ----------------------------------------
// sizes
// ----------------------------------------
`define TDIS_W          14
`define STK_DEPTH       8
`define STK_PTR_W       4
`define STK_W           24
`define STK_FULL_PTR    4'h8

`endif

// File: bench/priority_interrupt_control_props.sv
`timescale 1ns/1ps
`include "prio_int_consts.vh"
// --------------------
// port checks
// --------------------
module priority_interrupt_control_props
(
    input wire        clk,
    input wire        arst_n,
    input wire [7:0]  addr,
    input wire        rd,
    input wire [15:0] rdata,
    input wire        take_ack,
    input wire        ret_strobe,
    input wire        irq_req,
    input wire [3:0]  irq_vec,
    input wire [3:0]  irq_lvl,
    input wire [3:0]  cpu_level,
    input wire        ret_valid
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("rdata not zero outside read slot");
    a_prio_spare: assert property ($past(rd) && $past(addr) == `ADDR_PRIO_A
        |-> (rdata & 16'h8888) == 16'h0000) else $error("priority spare bits set");
    a_ctl2_spare: assert property ($past(rd) && $past(addr) == `ADDR_ICON2
        |-> (rdata & 16'hf88f) == 16'h0000) else $error("control two spare bits set");
    a_take_clears: assert property (take_ack && irq_req |=> !irq_req)
        else $error("request shown right after take");
    a_take_level: assert property (take_ack && irq_req |=> cpu_level == $past(irq_lvl))
        else $error("cpu level not raised by take");
    a_ret_cause: assert property (ret_valid |-> $past(ret_strobe))
        else $error("return without strobe");
    a_trap_level: assert property (irq_req && irq_vec < 4'h4
        |-> irq_lvl == {2'b10, irq_vec[1:0]}) else $error("trap level wrong");
    // while the level moves the shown request may lag by a cycle
    a_user_above: assert property (irq_req && irq_vec >= 4'h4 && $stable(cpu_level)
        |-> irq_lvl > cpu_level && irq_lvl <= 4'h7) else $error("user request not above cpu");
endmodule // priority_interrupt_control_props

bind priority_interrupt_control priority_interrupt_control_props u_props (.clk, .arst_n,
    .addr, .rd, .rdata, .take_ack, .ret_strobe, .irq_req, .irq_vec, .irq_lvl, .cpu_level,
    .ret_valid);

// File: bench/core_model.sv
`timescale 1ns/1ps
// --------------------
// core stand-in
// --------------------
module core_model
(
    input  wire        clk,
    input  wire        arst_n,
    input  wire        irq_req,
    input  wire        go,
    input  wire        slow,
    output reg         take_ack,
    output reg  [15:0] take_pc,
    output reg         ret_strobe,
    output reg         busy
);
    reg [7:0] left;
    // one handler at a time: keeps the expected return pc trivial
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {take_ack, ret_strobe, busy, left} <= 11'h000;
            take_pc <= 16'h0100;
        end
        else
        begin
            take_ack   <= 1'b0;
            ret_strobe <= 1'b0;
            if (!busy && go && irq_req)
            begin
                take_ack <= 1'b1;
                take_pc  <= take_pc + 16'h0002;
                busy     <= 1'b1;
                left     <= slow ? 8'd40 : 8'd3;
            end
            else if (busy && !take_ack)
            begin
                if (left == 8'd0)
                begin
                    ret_strobe <= 1'b1;
                    busy       <= 1'b0;
                end
                else
                    left <= left - 8'd1;
            end
        end
    end
endmodule // core_model

// File: bench/priority_interrupt_control_tb_top.sv
`timescale 1ns/1ps
`include "prio_int_consts.vh"
module priority_interrupt_control_tb_top;
    reg         clk, arst_n, wr, rd, go, slow;
    reg  [7:0]  addr, src_event, en, ev, r;
    reg  [3:0]  trap_event;
    reg  [15:0] wdata, pa, last_pc;
    wire [15:0] rdata, take_pc, ret_pc;
    wire [3:0]  irq_vec, irq_lvl, cpu_level;
    wire        take_ack, ret_strobe, busy, irq_req, ret_valid, int_out;
    integer     errors, samples_checked, seed, takes, rets, k;

    priority_interrupt_control u_dut (.clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata,
        .src_event, .trap_event, .take_ack, .take_pc, .ret_strobe, .irq_req, .irq_vec,
        .irq_lvl, .cpu_level, .ret_valid, .ret_pc, .int_out);
    core_model u_core (.clk, .arst_n, .irq_req, .go, .slow, .take_ack, .take_pc,
        .ret_strobe, .busy);
    // --------------------
    // helpers
    // --------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input [31:0] seen, input [31:0] exp, input [95:0] what);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("BAD %0s exp %h seen %h", what, exp, seen);
        end
    end
    endtask
    task wreg(input [7:0] a, input [15:0] d);
    begin
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    end
    endtask
    task rchk(input [7:0] a, input [15:0] e);
    begin
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 check(rdata, e, "rdata");
    end
    endtask
    task pulse(input [7:0] s, input [3:0] t);
    begin
        @(posedge clk);
        src_event  <= s;
        trap_event <= t;
        @(posedge clk);
        src_event  <= 8'h00;
        trap_event <= 4'h0;
    end
    endtask
    task rq(input [8:0] e);
    begin
        repeat (3) @(posedge clk);
        #1 check({irq_req, irq_req ? {irq_lvl, irq_vec} : 8'h00}, e, "request");
    end
    endtask
    // same word goes to all three priority registers; returns {level, vector}
    function [7:0] exp_req(input [15:0] p, input [7:0] act);
        reg [2:0] v;
        integer   j;
    begin
        exp_req = 8'h00;
        for (j = 0; j < 8; j = j + 1)
        begin
            v = p[(j < 4 ? j : j < 6 ? j - 4 : j - 5) * 4 +: 3];
            if (act[j] && v > exp_req[6:4])
                exp_req = {1'b0, v, j[3:0] + 4'h4};
        end
    end
    endfunction
    task wrap_up;
    begin
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        if (take_ack && irq_req)
        begin
            last_pc <= take_pc;
            takes   <= takes + 1;
        end
        if (ret_valid)
        begin
            rets <= rets + 1;
            check(ret_pc, last_pc, "ret_pc");
        end
    end
    // run needs about 560 cycles; 5000 means a hang
    initial
    begin
        #250000;
        errors = errors + 1;
        wrap_up;
    end
    // --------------------
    // scenarios
    // --------------------
    initial
    begin
        {arst_n, wr, rd, go, slow, src_event, trap_event, addr, wdata} = 0;
        {errors, samples_checked, takes, rets} = 0;
        seed = 32'hd6ef;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        rchk(`ADDR_PRIO_A, 16'h4444);
        rchk(`ADDR_PRIO_B, 16'h0044);
        rchk(`ADDR_ICON2, 16'h0440);
        rchk(8'h10, 16'h0000);
        wreg(`ADDR_PRIO_A, 16'hffff);
        rchk(`ADDR_PRIO_A, 16'h7777);
        for (k = 0; k < 20; k = k + 1)
        begin
            pa = k ? $random(seed) : 16'h3333;
            en = k ? $random(seed) : 8'hff;
            ev = k ? $random(seed) : 8'h60;
            wreg(`ADDR_PEND, 16'h00ff);
            wreg(`ADDR_PRIO_A, pa);
            wreg(`ADDR_PRIO_B, pa);
            wreg(`ADDR_ICON2, pa);
            wreg(`ADDR_ENABLE, {8'h00, en});
            pulse(ev, 4'h0);
            r = exp_req(pa, ev & en);
            rq({|r[7:4], r});
            check(int_out, |(ev & en), "int_out");
        end
        wreg(`ADDR_PRIO_A, 16'h7654);
        wreg(`ADDR_ENABLE, 16'h000f);
        pulse(8'h0f, 4'h0);
        rq(9'h177);
        wreg(`ADDR_STATUS, 16'h000e);
        rq(9'h000);
        check(cpu_level, 4'h7, "cpu_level");
        pulse(8'h00, 4'h2);
        rq(9'h191);
        wreg(`ADDR_ICON1, 16'h0002);
        rq(9'h000);
        wreg(`ADDR_STATUS, 16'h0000);
        wreg(`ADDR_TDIS, 16'd60);
        rq(9'h177);
        wreg(`ADDR_PEND, 16'h0008);
        rq(9'h000);
        rchk(`ADDR_ICON1, 16'h4000);
        repeat (60) @(posedge clk);
        rq(9'h166);
        rchk(`ADDR_ICON1, 16'h0000);
        @(posedge clk);
        go <= 1'b1;
        repeat (60) @(posedge clk);
        go <= 1'b0;
        check(takes > 1, 1'b1, "retake");
        repeat (10) @(posedge clk);
        wreg(`ADDR_PEND, 16'h00ff);
        wreg(`ADDR_ICON1, 16'h8000);
        wreg(`ADDR_STATUS, 16'h00e1);
        slow <= 1'b1;
        pulse(8'h01, 4'h0);
        go <= 1'b1;
        repeat (4) @(posedge clk);
        go <= 1'b0;
        pulse(8'h02, 4'h0);
        rq(9'h000);
        check(busy, 1'b1, "busy");
        rchk(`ADDR_STATUS, 16'h00e9);
        repeat (50) @(posedge clk);
        rchk(`ADDR_STATUS, 16'h00e1);
        check(cpu_level, 4'h0, "cpu_level");
        check(rets, takes, "returns");
        wrap_up;
    end
endmodule // priority_interrupt_control_tb_top
